//--- logic/status_pkg.sv
package status_pkg;

  // ************************************************************
  // Status summary byte bit positions
  // ************************************************************
  localparam int BIT_FILL_EXPIRED = 0;
  localparam int BIT_FILL_STATE = 1;
  localparam int BIT_ALARM_SUM = 2;
  localparam int BIT_SERIAL_MAV = 3;
  localparam int BIT_BUS_MAV = 4;
  localparam int BIT_STD_SUM = 5;
  localparam int BIT_REQ_SUM = 6;
  localparam int BIT_UNUSED = 7;

  // ************************************************************
  // Register selects for queries and writes
  // ************************************************************
  localparam logic [2:0] SEL_STB = 3'h0;
  localparam logic [2:0] SEL_REQ_EN = 3'h1;
  localparam logic [2:0] SEL_STD_EVT = 3'h2;
  localparam logic [2:0] SEL_STD_EN = 3'h3;
  localparam logic [2:0] SEL_ALM_COND = 3'h4;
  localparam logic [2:0] SEL_ALM_EVT = 3'h5;
  localparam logic [2:0] SEL_ALM_EN = 3'h6;

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] STD_EVT_MASK = 8'hbd;
  localparam logic [7:0] ALM_MASK = 8'h7f;
  localparam logic [7:0] STB_MASK = 8'h7f;

  // ************************************************************
  // Keyword checker states
  // ************************************************************
  typedef enum logic [1:0] {
    KW_IDLE = 2'b00,
    KW_MATCH = 2'b01,
    KW_BAD = 2'b10
  } kw_state_t;

endpackage

//--- logic/status_byte_srq.sv
`timescale 1ns/1ps
module status_byte_srq
  import status_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic power_on_clear_in,
  input wire logic fill_expired_in,
  input wire logic fill_energized_in,
  input wire logic serial_buf_nonempty_in,
  input wire logic bus_buf_nonempty_in,
  input wire logic [7:0] std_event_in,
  input wire logic [7:0] alarm_active_in,
  input wire logic measure_done_in,
  input wire logic clear_status_in,
  input wire logic write_in,
  input wire logic query_in,
  input wire logic [2:0] select_in,
  input wire logic [7:0] write_data_in,
  input wire logic serial_poll_in,
  input wire logic kw_start_in,
  input wire logic kw_char_valid_in,
  input wire logic [7:0] kw_char_in,
  input wire logic kw_short_end_in,
  input wire logic kw_end_in,
  output logic [7:0] query_data_out,
  output logic query_valid_out,
  output logic [7:0] poll_data_out,
  output logic poll_valid_out,
  output logic srq_out,
  output logic kw_ok_out,
  output logic kw_error_out
);

  // ************************************************************
  // Pin synchronisers for asynchronous instrument levels
  // ************************************************************
  // Only the second stage feeds logic; the first may still be settling.
  logic [3:0] pins_meta_reg;
  logic [3:0] pins_sync_reg;
  logic [3:0] pins_raw;

  assign pins_raw = {bus_buf_nonempty_in, serial_buf_nonempty_in, fill_energized_in, fill_expired_in};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pins_meta_reg <= 4'h0;
      pins_sync_reg <= 4'h0;
    end else begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // ************************************************************
  // Event, condition and enable registers
  // ************************************************************
  logic [7:0] std_evt_reg;
  logic [7:0] std_evt_next;
  logic [7:0] alm_evt_reg;
  logic [7:0] alm_evt_next;
  logic [7:0] alm_cond_reg;
  logic [7:0] std_en_reg;
  logic [7:0] alm_en_reg;
  logic [7:0] req_en_reg;
  logic por_done_reg;

  // One decode serves every strobe that acts on a single register.
  function automatic logic sel_match(input logic [2:0] sel, input logic [2:0] code);
    sel_match = (sel == code);
  endfunction

  wire rd_std_evt = query_in && sel_match(select_in, SEL_STD_EVT);
  wire rd_alm_evt = query_in && sel_match(select_in, SEL_ALM_EVT);
  wire wr_req_en = write_in && sel_match(select_in, SEL_REQ_EN);
  wire wr_std_en = write_in && sel_match(select_in, SEL_STD_EN);
  wire wr_alm_en = write_in && sel_match(select_in, SEL_ALM_EN);

  // New events win over a clear in the same cycle so none is lost.
  assign std_evt_next = ((clear_status_in || rd_std_evt) ? ZERO_BYTE : std_evt_reg)
                        | (std_event_in & STD_EVT_MASK);
  assign alm_evt_next = ((clear_status_in || rd_alm_evt) ? ZERO_BYTE : alm_evt_reg)
                        | (alarm_active_in & ALM_MASK);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      std_evt_reg <= ZERO_BYTE;
      alm_evt_reg <= ZERO_BYTE;
      alm_cond_reg <= ZERO_BYTE;
    end else begin
      std_evt_reg <= std_evt_next;
      alm_evt_reg <= alm_evt_next;
      // The condition copy moves only on a finished measurement, never on a read.
      if (measure_done_in) begin
        alm_cond_reg <= alarm_active_in & ALM_MASK;
      end
    end
  end

  // Enable masks are kept across rst_in unless power-on-clear is set, which
  // models persistence; the first cycle after reset applies the clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      por_done_reg <= 1'b0;
    end else begin
      por_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!por_done_reg && !rst_in && power_on_clear_in) begin
      req_en_reg <= ZERO_BYTE;
      std_en_reg <= ZERO_BYTE;
      alm_en_reg <= ZERO_BYTE;
    end else if (!rst_in) begin
      // A write of zero clears a mask like any other value.
      if (wr_req_en) begin
        req_en_reg <= write_data_in & STB_MASK;
      end
      if (wr_std_en) begin
        std_en_reg <= write_data_in;
      end
      if (wr_alm_en) begin
        alm_en_reg <= write_data_in;
      end
    end
  end

  // ************************************************************
  // Status summary byte
  // ************************************************************
  logic [7:0] stb_live;
  // The previous byte resets to zero, like idle pins, so no false rise follows reset.
  logic [7:0] stb_prev_reg;
  logic req_sum_reg;
  logic srq_reg;
  wire std_sum = |(std_evt_reg & std_en_reg);
  wire alm_sum = |(alm_evt_reg & alm_en_reg);
  // Bit 7 cannot be enabled: writes to req_en_reg pass through STB_MASK,
  // which clears bit 7, so it never starts a request by itself.
  wire [7:0] rise = stb_live & ~stb_prev_reg & req_en_reg;

  // Bit 7 is tied low; unused standard event bits are masked at the input.
  always_comb begin
    stb_live = ZERO_BYTE;
    stb_live[BIT_FILL_EXPIRED] = pins_sync_reg[0];
    stb_live[BIT_FILL_STATE] = pins_sync_reg[1];
    stb_live[BIT_ALARM_SUM] = alm_sum;
    stb_live[BIT_SERIAL_MAV] = pins_sync_reg[2];
    stb_live[BIT_BUS_MAV] = pins_sync_reg[3];
    stb_live[BIT_STD_SUM] = std_sum;
    stb_live[BIT_REQ_SUM] = req_sum_reg;
    stb_live[BIT_UNUSED] = 1'b0;
  end

  // Bit 6 is sticky: it sets on an enabled rising edge and drops on poll or
  // clear-status, so a level that merely stays high cannot re-raise it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stb_prev_reg <= ZERO_BYTE;
      req_sum_reg <= 1'b0;
      srq_reg <= 1'b0;
    end else begin
      stb_prev_reg <= stb_live;
      if (|rise) begin
        req_sum_reg <= 1'b1;
        srq_reg <= 1'b1;
      end else if (serial_poll_in || clear_status_in) begin
        req_sum_reg <= 1'b0;
        srq_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Query and poll answers
  // ************************************************************
  // A status-byte query (SEL_STB) and a poll both take the live byte, so the two answers agree
  // whenever they fall in the same cycle.
  logic [7:0] query_mux;
  logic [7:0] query_data_reg;
  logic query_valid_reg;
  logic [7:0] poll_data_reg;
  logic poll_valid_reg;

  always_comb begin
    if (select_in == SEL_STB) begin
      query_mux = stb_live;
    end else if (select_in == SEL_REQ_EN) begin
      query_mux = req_en_reg;
    end else if (select_in == SEL_STD_EVT) begin
      query_mux = std_evt_reg;
    end else if (select_in == SEL_STD_EN) begin
      query_mux = std_en_reg;
    end else if (select_in == SEL_ALM_COND) begin
      query_mux = alm_cond_reg;
    end else if (select_in == SEL_ALM_EVT) begin
      query_mux = alm_evt_reg;
    end else if (select_in == SEL_ALM_EN) begin
      query_mux = alm_en_reg;
    end else begin
      query_mux = ZERO_BYTE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      query_data_reg <= ZERO_BYTE;
      query_valid_reg <= 1'b0;
      poll_data_reg <= ZERO_BYTE;
      poll_valid_reg <= 1'b0;
    end else begin
      query_valid_reg <= query_in;
      if (query_in) begin
        query_data_reg <= query_mux;
      end
      poll_valid_reg <= serial_poll_in;
      if (serial_poll_in) begin
        poll_data_reg <= stb_live;
      end
    end
  end

  // ************************************************************
  // Keyword spelling checker
  // ************************************************************
  // Characters arrive upper-cased. A keyword is legal if it ends exactly at
  // the short-form length or exactly at the full length; only a zero character (8'h00) errs.
  kw_state_t kw_state_reg;
  kw_state_t kw_state_next;
  logic kw_ok_reg;
  logic kw_error_reg;
  wire kw_legal = kw_short_end_in || kw_end_in;
  wire kw_bad_char = kw_char_valid_in && (kw_char_in == 8'h00);

  always_comb begin
    kw_state_next = kw_state_reg;
    case (kw_state_reg)
      KW_IDLE: begin
        if (kw_start_in) begin
          kw_state_next = KW_MATCH;
        end
      end
      KW_MATCH: begin
        if (kw_char_valid_in && kw_char_in == 8'h00) begin
          kw_state_next = KW_BAD;
        end else if (kw_legal) begin
          kw_state_next = KW_IDLE;
        end
      end
      default: begin
        kw_state_next = KW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      kw_state_reg <= KW_IDLE;
      kw_ok_reg <= 1'b0;
      kw_error_reg <= 1'b0;
    end else begin
      kw_state_reg <= kw_state_next;
      kw_ok_reg <= (kw_state_reg == KW_MATCH) && kw_legal && !kw_bad_char;
      // The bad state only parks the walker for one cycle; the error itself
      // is reported once, when the illegal character is seen.
      kw_error_reg <= (kw_state_reg == KW_MATCH) && kw_bad_char;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  assign query_data_out = query_data_reg;
  assign query_valid_out = query_valid_reg;
  assign poll_data_out = poll_data_reg;
  assign poll_valid_out = poll_valid_reg;
  assign srq_out = srq_reg;
  assign kw_ok_out = kw_ok_reg;
  assign kw_error_out = kw_error_reg;

endmodule // status_byte_srq

//--- tb/host_ctrl.sv
`timescale 1ns/1ps
module host_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic srq_in,
  input wire logic auto_in,
  input wire logic [4:0] delay_in,
  output logic poll_out
);
  // ************************************************************
  // Host reaction to a service request
  // ************************************************************
  // The wait is programmable, so the bench can poll both promptly and slowly.
  logic [4:0] wait_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in || poll_out || !(srq_in && auto_in)) begin
      wait_reg <= 5'h00;
      poll_out <= 1'b0;
    end else if (wait_reg == delay_in) begin
      wait_reg <= 5'h00;
      poll_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 5'h01;
    end
  end
endmodule // host_ctrl

//--- tb/status_chk.sv
`timescale 1ns/1ps
module status_chk
  import status_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_status_in,
  input wire logic query_in,
  input wire logic [2:0] select_in,
  input wire logic serial_poll_in,
  input wire logic kw_start_in,
  input wire logic kw_end_in,
  input wire logic [7:0] query_data_out,
  input wire logic query_valid_out,
  input wire logic [7:0] poll_data_out,
  input wire logic poll_valid_out,
  input wire logic srq_out,
  input wire logic kw_ok_out,
  input wire logic kw_error_out
);
  // ************************************************************
  // Port relations
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence full_kw;
    kw_start_in ##1 kw_end_in;
  endsequence
  chk_query_answer_next: assert property (query_in |=> query_valid_out) else $error("query unanswered");
  chk_poll_answer_next: assert property (serial_poll_in |=> poll_valid_out) else $error("poll unanswered");
  chk_stb_top_zero: assert property (query_valid_out && $past(select_in) == SEL_STB |-> !query_data_out[7])
    else $error("status bit 7 set");
  chk_poll_top_zero: assert property (poll_valid_out |-> !poll_data_out[7]) else $error("poll bit 7 set");
  chk_poll_summary_bit: assert property (serial_poll_in |=> poll_data_out[6] == $past(srq_out))
    else $error("poll bit 6 wrong");
  chk_srq_stands: assert property (srq_out && !serial_poll_in && !clear_status_in |=> srq_out)
    else $error("request dropped");
  chk_stb_query_keeps: assert property (query_in && select_in == SEL_STB && srq_out |=> query_data_out[6])
    else $error("query lost bit 6");
  chk_full_kw_ok: assert property (full_kw |=> kw_ok_out && !kw_error_out) else $error("keyword refused");
  chk_kw_one_answer: assert property (!(kw_ok_out && kw_error_out)) else $error("keyword both");
  chk_kw_error_once: assert property (kw_error_out |=> !kw_error_out) else $error("keyword error repeated");
  chk_unmapped_zero: assert property (query_in && select_in == 3'h7 |=> query_data_out == ZERO_BYTE)
    else $error("unmapped read");
endmodule // status_chk
bind status_byte_srq status_chk i_chk(.clk_in(clk_in), .rst_in(rst_in), .clear_status_in(clear_status_in),
  .query_in(query_in), .select_in(select_in), .serial_poll_in(serial_poll_in), .kw_start_in(kw_start_in),
  .kw_end_in(kw_end_in), .query_data_out(query_data_out), .query_valid_out(query_valid_out),
  .poll_data_out(poll_data_out), .poll_valid_out(poll_valid_out), .srq_out(srq_out), .kw_ok_out(kw_ok_out),
  .kw_error_out(kw_error_out));

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import status_pkg::*;;
  logic clk_in, rst_in, poc, fx, fe, sne, bne, meas, clr, wen, qry, kws, kwv, kwse, kwe, auto, poll;
  logic [7:0] sev, alm, wd, kch, qd, pd;
  logic [2:0] sel;
  logic [4:0] dly;
  logic qv, pv, srq, kok, kerr;
  int n_fail, n_tests;
  status_byte_srq i_dut(.clk_in(clk_in), .rst_in(rst_in), .power_on_clear_in(poc), .fill_expired_in(fx),
    .fill_energized_in(fe), .serial_buf_nonempty_in(sne), .bus_buf_nonempty_in(bne), .std_event_in(sev),
    .alarm_active_in(alm), .measure_done_in(meas), .clear_status_in(clr), .write_in(wen), .query_in(qry),
    .select_in(sel), .write_data_in(wd), .serial_poll_in(poll), .kw_start_in(kws), .kw_char_valid_in(kwv),
    .kw_char_in(kch), .kw_short_end_in(kwse), .kw_end_in(kwe), .query_data_out(qd), .query_valid_out(qv),
    .poll_data_out(pd), .poll_valid_out(pv), .srq_out(srq), .kw_ok_out(kok), .kw_error_out(kerr));
  host_ctrl i_host(.clk_in(clk_in), .rst_in(rst_in), .srq_in(srq), .auto_in(auto), .delay_in(dly),
    .poll_out(poll));
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    {sel, wd, wen} = {s, d, 1'b1};
    tick();
    wen = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] exp);
    {sel, qry} = {s, 1'b1};
    tick();
    qry = 1'b0;
    chk({7'h00, qv}, 8'h01);
    chk(qd, exp);
    tick();
  endtask
  // A poll is a one-cycle answer, so it is caught in the cycle it appears.
  task automatic wait_poll();
    for (int i = 0; i < 60 && pv !== 1'b1; i++) tick();
    if (pv !== 1'b1) begin
      chk({7'h00, pv}, 8'h01);
      conclude();
    end
  endtask
  task automatic kw(input int k, input logic e);
    kws = 1'b1;
    tick();
    kws = 1'b0;
    {kwe, kwse, kwv} = 3'b100 >> k;
    tick();
    {kwe, kwse, kwv} = 3'b000;
    chk({6'h00, kerr, kok}, {6'h00, e, !e});
    tick();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    {poc, rst_in, fx, fe, sne, bne, meas, clr, wen, qry, kws, kwv, kwse, kwe, auto} = 15'h6000;
    {sev, alm, wd, kch, sel, dly} = {32'h0, 3'h0, 5'h02};
    {n_fail, n_tests} = 0;
    repeat (6) tick();
    rst_in = 1'b0;
    repeat (2) tick();
    rd(SEL_REQ_EN, 8'h00);
    wr(SEL_STD_EN, 8'h21);
    wr(SEL_ALM_EN, 8'h05);
    wr(SEL_STB, 8'hff);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    rd(SEL_STD_EN, 8'h21);
    rd(SEL_ALM_EN, 8'h05);
    rd(SEL_STB, 8'h00);
    rd(3'h7, 8'h00);
    $display("mask test done");
    {alm, meas} = {8'h01, 1'b1};
    tick();
    {alm, meas} = 9'h000;
    rd(SEL_ALM_COND, 8'h01);
    rd(SEL_ALM_COND, 8'h01);
    meas = 1'b1;
    tick();
    meas = 1'b0;
    rd(SEL_ALM_COND, 8'h00);
    rd(SEL_STB, 8'h04);
    rd(SEL_ALM_EVT, 8'h01);
    rd(SEL_ALM_EVT, 8'h00);
    rd(SEL_STB, 8'h00);
    $display("alarm test done");
    sev = 8'h20;
    tick();
    sev = 8'h00;
    rd(SEL_STB, 8'h20);
    rd(SEL_STD_EVT, 8'h20);
    rd(SEL_STB, 8'h00);
    sev = 8'h01;
    tick();
    sev = 8'h00;
    rd(SEL_STB, 8'h20);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    rd(SEL_STD_EVT, 8'h00);
    {fx, fe} = 2'b11;
    repeat (4) tick();
    rd(SEL_STB, 8'h03);
    {fx, fe} = 2'b00;
    $display("event test done");
    wr(SEL_REQ_EN, 8'h18);
    bne = 1'b1;
    repeat (4) tick();
    chk({7'h00, srq}, 8'h01);
    rd(SEL_STB, 8'h50);
    chk({7'h00, srq}, 8'h01);
    auto = 1'b1;
    wait_poll();
    chk(pd, 8'h50);
    chk({7'h00, srq}, 8'h00);
    repeat (10) tick();
    chk({7'h00, srq}, 8'h00);
    {dly, sne} = {5'h14, 1'b1};
    wait_poll();
    chk(pd, 8'h58);
    {sne, bne, auto} = 3'b000;
    repeat (4) tick();
    rd(SEL_STB, 8'h00);
    wr(SEL_REQ_EN, 8'h02);
    fe = 1'b1;
    repeat (5) tick();
    chk({7'h00, srq}, 8'h01);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    chk({7'h00, srq}, 8'h00);
    wr(SEL_REQ_EN, 8'h00);
    rd(SEL_REQ_EN, 8'h00);
    $display("request test done");
    {poc, rst_in} = 2'b01;
    repeat (2) tick();
    rst_in = 1'b0;
    repeat (2) tick();
    rd(SEL_STD_EN, 8'h21);
    rd(SEL_ALM_EN, 8'h05);
    rd(SEL_STB, 8'h02);
    {poc, rst_in} = 2'b11;
    repeat (2) tick();
    rst_in = 1'b0;
    repeat (2) tick();
    rd(SEL_STD_EN, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 3; k++) kw(k, k == 2);
    $display("keyword test done");
    conclude();
  end
endmodule // tb_top
